// ### rtl/lvtpc_top.sv
/*
  Over-level detection, neutral current mismatch and voltage phase compensation
  with their status, mask, threshold and calibration registers.
  Assumes samples and the sample strobe come from the signal path on sys_clk and
  that the register port is driven by the serial front end on the same clock.
*/
`default_nettype none
module lvtpc_top
  import lvtpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sample_strobe,
  input wire logic [23:0] phase_a_voltage_sample,
  input wire logic [23:0] phase_b_voltage_sample,
  input wire logic [23:0] phase_c_voltage_sample,
  input wire logic [23:0] phase_a_current_sample,
  input wire logic [23:0] phase_b_current_sample,
  input wire logic [23:0] phase_c_current_sample,
  input wire logic [23:0] neutral_current_sample,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic secondary_irq_n,
  output logic neutral_rms_source_select,
  output logic [2:0] comp_voltage_valid,
  output logic [23:0] comp_phase_a_voltage,
  output logic [23:0] comp_phase_b_voltage,
  output logic [23:0] comp_phase_c_voltage
);
  logic [23:0] overvoltage_threshold;
  logic [23:0] overcurrent_threshold;
  logic [27:0] current_sum_mismatch_threshold;
  logic [27:0] phase_current_sum;
  logic [2:0][9:0] phase_delay_calibration;
  logic sample_done_flag;
  logic overcurrent_flag;
  logic overvoltage_flag;
  logic neutral_mismatch_flag;
  logic [2:0] overcurrent_phase_bits;
  logic [2:0] overvoltage_phase_bits;
  logic [2:0] secondary_event_enables;
  logic [2:0][23:0] volt;
  logic [2:0][23:0] curr;
  logic [2:0] over_v;
  logic [2:0] over_i;
  logic [27:0] next_sum;
  logic [27:0] sum_mag;
  logic [27:0] neu_mag;
  logic [27:0] mis_diff;
  logic mis_hit;
  logic secondary_event_flags_wr;
  logic clr_oi;
  logic clr_ov;
  logic clr_mis;
  logic clr_done;
  logic [31:0] next_rdata;
  logic [15:0] step_count;
  logic [2:0][23:0] comp_data;

  // Magnitude of a signed 24-bit sample; the most negative code maps to its own magnitude.
  function automatic logic [23:0] fn_mag(input logic [23:0] s);
    fn_mag = s[23] ? 24'(24'h00_0000 - s) : s;
  endfunction

  // Over-level test with the two documented end points handled first.
  function automatic logic fn_over(input logic [23:0] mag, input logic [23:0] thr);
    if (thr == LEVEL_FULL_SCALE)
      fn_over = 1'b0;
    else if (thr == 24'h00_0000)
      fn_over = 1'b1;
    else
      fn_over = mag > thr;
  endfunction

  // Register port address match, used by every write and read decode.
  function automatic logic fn_hit(input logic [7:0] a, input logic [7:0] target);
    fn_hit = a == target;
  endfunction

  assign volt = {phase_c_voltage_sample, phase_b_voltage_sample, phase_a_voltage_sample};
  assign curr = {phase_c_current_sample, phase_b_current_sample, phase_a_current_sample};

  // One comparator pair per phase, evaluated on the values present at the strobe.
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_level
      assign over_v[g] = fn_over(fn_mag(volt[g]), overvoltage_threshold);
      assign over_i[g] = fn_over(fn_mag(curr[g]), overcurrent_threshold);
    end
  endgenerate

  // Sum of the phase currents, sign-extended to the 28-bit register width.
  assign next_sum = 28'({{4{curr[0][23]}}, curr[0]} + {{4{curr[1][23]}}, curr[1]}
                        + {{4{curr[2][23]}}, curr[2]});
  assign sum_mag = next_sum[27] ? 28'(28'h000_0000 - next_sum) : next_sum;
  assign neu_mag = {4'h0, fn_mag(neutral_current_sample)};
  assign mis_diff = (sum_mag >= neu_mag) ? 28'(sum_mag - neu_mag) : 28'(neu_mag - sum_mag);
  // A zero or negative threshold keeps the mismatch event firing on every sample.
  assign mis_hit = ($signed(current_sum_mismatch_threshold) <= 28'sh000_0000)
                   || (mis_diff > current_sum_mismatch_threshold);

  // Write-one-to-clear decode on the status registers.
  assign secondary_event_flags_wr = reg_wr && fn_hit(reg_addr, ADDR_SECONDARY_EVENT_FLAGS);
  assign clr_oi = secondary_event_flags_wr && reg_wdata[OI_BIT];
  assign clr_ov = secondary_event_flags_wr && reg_wdata[OV_BIT];
  assign clr_mis = secondary_event_flags_wr && reg_wdata[MIS_BIT];
  assign clr_done = reg_wr && fn_hit(reg_addr, ADDR_PRIMARY_EVENT_FLAGS) && reg_wdata[DONE_BIT];

  // Host-written thresholds, calibrations, enables and configuration.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      overvoltage_threshold <= THR_RESET;
      overcurrent_threshold <= THR_RESET;
      current_sum_mismatch_threshold <= MIS_THR_RESET;
      phase_delay_calibration <= {3{PHCAL_RESET}};
      secondary_event_enables <= 3'b000;
      neutral_rms_source_select <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (fn_hit(reg_addr, ADDR_OV_THR))
        overvoltage_threshold <= reg_wdata[23:0];
      if (fn_hit(reg_addr, ADDR_OI_THR))
        overcurrent_threshold <= reg_wdata[23:0];
      if (fn_hit(reg_addr, ADDR_MIS_THR))
        current_sum_mismatch_threshold <= {{4{reg_wdata[23]}}, reg_wdata[23:0]};
      for (int p = 0; p < 3; p++)
        if (fn_hit(reg_addr, 8'(ADDR_PHCAL_A + 8'(p))))
          phase_delay_calibration[p] <= reg_wdata[9:0];
      if (fn_hit(reg_addr, ADDR_SECONDARY_EVENT_ENABLES))
        secondary_event_enables <= {reg_wdata[MIS_BIT], reg_wdata[OV_BIT], reg_wdata[OI_BIT]};
      if (fn_hit(reg_addr, ADDR_CONFIG))
        neutral_rms_source_select <= reg_wdata[NEUTRAL_RMS_SOURCE_SELECT_BIT];
    end
  end

  // Phase current sum and its completion flag, updated once per sample.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      phase_current_sum <= 28'h000_0000;
      sample_done_flag <= 1'b0;
    end
    else
    begin
      if (sample_strobe)
        phase_current_sum <= next_sum;
      // A new sample wins over a clear arriving in the same cycle.
      sample_done_flag <= sample_strobe || (sample_done_flag && !clr_done);
    end
  end

  // Overcurrent flag and the phases that tripped it.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      overcurrent_flag <= 1'b0;
      overcurrent_phase_bits <= 3'b000;
    end
    else
    begin
      if (sample_strobe && (over_i != 3'b000))
      begin
        overcurrent_flag <= 1'b1;
        overcurrent_phase_bits <= (clr_oi ? 3'b000 : overcurrent_phase_bits) | over_i;
      end
      else if (clr_oi)
      begin
        overcurrent_flag <= 1'b0;
        overcurrent_phase_bits <= 3'b000;
      end
    end
  end

  // Overvoltage flag and its phase bits; they stay set without a clear.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      overvoltage_flag <= 1'b0;
      overvoltage_phase_bits <= 3'b000;
    end
    else
    begin
      if (sample_strobe && (over_v != 3'b000))
      begin
        overvoltage_flag <= 1'b1;
        overvoltage_phase_bits <= (clr_ov ? 3'b000 : overvoltage_phase_bits) | over_v;
      end
      else if (clr_ov)
      begin
        overvoltage_flag <= 1'b0;
        overvoltage_phase_bits <= 3'b000;
      end
    end
  end

  // Neutral mismatch flag, checked once per sample.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      neutral_mismatch_flag <= 1'b0;
    else
      neutral_mismatch_flag <= (sample_strobe && mis_hit)
                               || (neutral_mismatch_flag && !clr_mis);
  end

  // The interrupt line follows the enabled flags one clock later, so it is glitch free.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      secondary_irq_n <= 1'b1;
    else
      secondary_irq_n <= !(|({neutral_mismatch_flag, overvoltage_flag, overcurrent_flag}
                             & secondary_event_enables));
  end

  // Read data, with unused upper bits and unmapped words returning zero.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (1'b1)
      fn_hit(reg_addr, ADDR_OV_THR): next_rdata = {8'h00, overvoltage_threshold};
      fn_hit(reg_addr, ADDR_OI_THR): next_rdata = {8'h00, overcurrent_threshold};
      fn_hit(reg_addr, ADDR_PHASE_CURRENT_SUM): next_rdata = {4'h0, phase_current_sum};
      fn_hit(reg_addr, ADDR_MIS_THR): next_rdata = {4'h0, current_sum_mismatch_threshold};
      fn_hit(reg_addr, ADDR_PRIMARY_EVENT_FLAGS): next_rdata[DONE_BIT] = sample_done_flag;
      fn_hit(reg_addr, ADDR_SECONDARY_EVENT_FLAGS):
      begin
        next_rdata[OI_BIT] = overcurrent_flag;
        next_rdata[OV_BIT] = overvoltage_flag;
        next_rdata[MIS_BIT] = neutral_mismatch_flag;
      end
      fn_hit(reg_addr, ADDR_SECONDARY_EVENT_ENABLES):
      begin
        next_rdata[OI_BIT] = secondary_event_enables[0];
        next_rdata[OV_BIT] = secondary_event_enables[1];
        next_rdata[MIS_BIT] = secondary_event_enables[2];
      end
      fn_hit(reg_addr, ADDR_PHASE_EVENT_SOURCE):
      begin
        next_rdata[OV_PHASE_LSB+:3] = overvoltage_phase_bits;
        next_rdata[OI_PHASE_LSB+:3] = overcurrent_phase_bits;
      end
      fn_hit(reg_addr, ADDR_CONFIG): next_rdata[NEUTRAL_RMS_SOURCE_SELECT_BIT] = neutral_rms_source_select;
      default:
      begin
        for (int p = 0; p < 3; p++)
          if (fn_hit(reg_addr, 8'(ADDR_PHCAL_A + 8'(p))))
            next_rdata = {22'h00_0000, phase_delay_calibration[p]};
      end
    endcase
  end

  // Read data is captured on the read strobe and held until the next read.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // Shared step timebase for the three voltage shifters.
  lvtpc_step_tick u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .step_tick(),
    .step_count(step_count)
  );

  // One shifter per phase voltage path.
  generate
    for (g = 0; g < 3; g++)
    begin : g_shift
      lvtpc_phase_shift u_shift (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .step_count(step_count),
        .in_valid(sample_strobe),
        .in_data(volt[g]),
        .cal(phase_delay_calibration[g]),
        .out_valid(comp_voltage_valid[g]),
        .out_data(comp_data[g])
      );
    end
  endgenerate

  assign comp_phase_a_voltage = comp_data[0];
  assign comp_phase_b_voltage = comp_data[1];
  assign comp_phase_c_voltage = comp_data[2];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ov_clear;
    secondary_event_flags_wr && reg_wdata[OV_BIT] && !sample_strobe;
  endsequence

  sequence s_sample;
    sample_strobe;
  endsequence

  chk_clear_ov_phase: assert property (s_ov_clear |=> !overvoltage_flag
    && overvoltage_phase_bits == 3'b000)
    else $error("Overvoltage clear left flag or phase bits set.");

  chk_irq_follows_mask: assert property (##1 secondary_irq_n ==
    !$past(|({neutral_mismatch_flag, overvoltage_flag, overcurrent_flag}
             & secondary_event_enables)))
    else $error("Interrupt line does not follow enabled flags.");

  chk_full_scale_quiet: assert property ((s_sample and
    overvoltage_threshold == LEVEL_FULL_SCALE) |=> !$rose(overvoltage_flag))
    else $error("Overvoltage reported at full-scale threshold.");

  chk_zero_level_trips: assert property ((s_sample and
    overcurrent_threshold == 24'h00_0000) |=> overcurrent_flag
    && overcurrent_phase_bits == 3'b111)
    else $error("Zero overcurrent threshold did not trip all phases.");

  chk_sum_and_done: assert property (s_sample |=> sample_done_flag
    && phase_current_sum == $past(next_sum))
    else $error("Current sum or done flag not updated.");

  chk_neg_mismatch: assert property ((s_sample and
    current_sum_mismatch_threshold[27]) |=> neutral_mismatch_flag ##1 neutral_mismatch_flag)
    else $error("Negative mismatch threshold did not flag.");

  chk_flag_sticky: assert property ((overcurrent_flag && !clr_oi) |=> overcurrent_flag)
    else $error("Overcurrent flag dropped without a clear.");

  chk_phcal_upper: assert property ((reg_rd && fn_hit(reg_addr, ADDR_PHCAL_A))
    |=> reg_rdata[31:10] == 22'h00_0000 && reg_rdata[9:0] == $past(phase_delay_calibration[0]))
    else $error("Calibration read returned bad upper bits.");
endmodule
`default_nettype wire

// ### include/lvtpc_pkg.sv
/*
  Shared constants for the level, tamper and phase compensation stage: register word
  addresses, field positions, reset values and the delay-step timing.
  Assumes a single 40 MHz clock domain and a word-wide register port fed by the
  serial port front end on the same clock.
*/
`default_nettype none
package lvtpc_pkg;
  // Register word addresses.
  localparam logic [7:0] ADDR_OV_THR = 8'h00;
  localparam logic [7:0] ADDR_OI_THR = 8'h01;
  localparam logic [7:0] ADDR_PHASE_CURRENT_SUM = 8'h02;
  localparam logic [7:0] ADDR_MIS_THR = 8'h03;
  localparam logic [7:0] ADDR_PHCAL_A = 8'h04;
  localparam logic [7:0] ADDR_PRIMARY_EVENT_FLAGS = 8'h07;
  localparam logic [7:0] ADDR_SECONDARY_EVENT_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_SECONDARY_EVENT_ENABLES = 8'h09;
  localparam logic [7:0] ADDR_PHASE_EVENT_SOURCE = 8'h0A;
  localparam logic [7:0] ADDR_CONFIG = 8'h0B;
  // Field positions.
  localparam int DONE_BIT = 17;
  localparam int OI_BIT = 17;
  localparam int OV_BIT = 18;
  localparam int MIS_BIT = 20;
  localparam int OV_PHASE_LSB = 9;
  localparam int OI_PHASE_LSB = 3;
  localparam int NEUTRAL_RMS_SOURCE_SELECT_BIT = 0;
  // Levels and reset values.
  localparam logic [23:0] LEVEL_FULL_SCALE = 24'h5A_7540;
  localparam logic [23:0] THR_RESET = 24'h00_0000;
  localparam logic [27:0] MIS_THR_RESET = 28'h000_0000;
  localparam logic [9:0] PHCAL_RESET = 10'h000;
  localparam logic [9:0] CAL_LAG_OFFSET = 10'h200;
  // Delay-step timing: one step is 0.976 us, a 1.024 MHz rate from the 40 MHz clock.
  localparam real STEP_PERIOD_US = 0.976;
  localparam int CLK_KHZ = 40000;
  localparam int STEP_KHZ = 1024;
  localparam logic [15:0] STEP_ACC_INC = 16'(STEP_KHZ);
  localparam logic [15:0] STEP_ACC_WRAP = 16'(CLK_KHZ);
  // Fixed latency in steps; leads deeper than 384 steps (up to 511) release at once instead.
  localparam logic [15:0] SHIFT_BASE_STEPS = 16'h0180;
  localparam int RING_DEPTH = 4;
endpackage
`default_nettype wire

// ### rtl/lvtpc_step_tick.sv
/*
  Fractional divider making the 1.024 MHz delay-step tick and a free step count.
  Assumes the 40 MHz system clock and a synchronous active-low reset.
*/
`default_nettype none
module lvtpc_step_tick
  import lvtpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic step_tick,
  output logic [15:0] step_count
);
  logic [15:0] acc;
  logic [16:0] acc_sum;

  // The step period is not a whole number of clocks, so an accumulator spreads the error.
  assign acc_sum = {1'b0, acc} + {1'b0, STEP_ACC_INC};

  // Tick generation and step counting.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      acc <= 16'h0000;
      step_tick <= 1'b0;
      step_count <= 16'h0000;
    end
    else if (acc_sum >= {1'b0, STEP_ACC_WRAP})
    begin
      acc <= 16'(acc_sum - {1'b0, STEP_ACC_WRAP});
      step_tick <= 1'b1;
      step_count <= step_count + 16'h0001;
    end
    else
    begin
      acc <= acc_sum[15:0];
      step_tick <= 1'b0;
    end
  end

  // Every tick moves the step count by exactly one, so releases land on whole steps.
  chk_step_advance: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step_tick |-> step_count == 16'($past(step_count) + 16'h0001))
    else $error("Step count did not advance with its tick.");
endmodule
`default_nettype wire

// ### rtl/lvtpc_phase_shift.sv
/*
  Per-phase voltage time shifter: each sample is replayed after a fixed base latency
  plus or minus the calibrated number of steps; leads deeper than the base latency release at once.
  Assumes samples arrive at 8 kHz, so at most four are in flight while the lag stays under 128 steps.
*/
`default_nettype none
module lvtpc_phase_shift
  import lvtpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] step_count,
  input wire logic in_valid,
  input wire logic [23:0] in_data,
  input wire logic [9:0] cal,
  output logic out_valid,
  output logic [23:0] out_data
);
  logic [23:0] data_mem [RING_DEPTH];
  logic [15:0] due_mem [RING_DEPTH];
  logic [1:0] wr_ptr;
  logic [1:0] rd_ptr;
  logic [2:0] fill;
  logic [15:0] shift;
  logic [15:0] slack;
  logic due_now;
  logic push;

  // Lead settings advance the voltage, lag settings (offset by 512) delay it.
  assign shift = (cal >= CAL_LAG_OFFSET) ? 16'(cal - CAL_LAG_OFFSET)
                                         : 16'(16'h0000 - 16'(cal));
  // A negative slack means the head sample is not yet due; the sign absorbs counter wrap.
  assign slack = 16'(step_count - due_mem[rd_ptr]);
  assign due_now = (fill != 3'd0) && !slack[15];
  assign push = in_valid && (fill != 3'(RING_DEPTH));

  // Sample store with its release time in steps.
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      data_mem[wr_ptr] <= in_data;
      due_mem[wr_ptr] <= 16'(step_count + SHIFT_BASE_STEPS + shift);
    end
  end

  // Pointers and replay of due samples.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 2'b00;
      rd_ptr <= 2'b00;
      fill <= 3'd0;
      out_valid <= 1'b0;
      out_data <= 24'h00_0000;
    end
    else
    begin
      out_valid <= due_now;
      if (due_now)
      begin
        out_data <= data_mem[rd_ptr];
        rd_ptr <= rd_ptr + 2'b01;
      end
      if (push)
      begin
        wr_ptr <= wr_ptr + 2'b01;
      end
      fill <= 3'(fill + {2'b00, push} - {2'b00, due_now});
    end
  end

  // A lead setting must bring the release in before the base latency, a lag setting not.
  chk_replay_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (push && cal != 10'h000) |=> ((16'(due_mem[$past(wr_ptr)] - $past(step_count))
    < SHIFT_BASE_STEPS) == ($past(cal) < CAL_LAG_OFFSET)))
    else $error("Release step on the wrong side of the base latency.");
endmodule
`default_nettype wire

// ### tb/lvtpc_host_model.sv
/*
  Host side of the register port: one word-wide access per call.
  Assumes the bench clock; every change is made on a falling edge.
*/
`default_nettype none
module lvtpc_host_model (
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle at time zero.
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0000_0000;
  end
  // A strobe stands over exactly one rising edge.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Released lines flip so that stale values cannot pass for live ones.
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ### tb/test_lvtpc_top.sv
/*
  Self-checking bench for the level, mismatch and phase shift stage.
  Assumes the host model drives the register port and the bench feeds samples.
*/
`default_nettype none
module test_lvtpc_top
  import lvtpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic strobe = 1'b0;
  logic [23:0] va, vb, vc, ia, ib, ic, inn;
  logic [7:0] reg_addr;
  logic reg_wr, reg_rd, irq_n, nsel;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0] cvalid;
  logic [23:0] ca, cb, cc;
  logic [31:0] exp_q[$];
  logic rd_taken = 1'b0;
  int n_errors = 0;
  int n_checks = 0;
  int at[3];
  int sh[3] = '{0, 63, -100};
  integer seed = 14;
  logic [23:0] r[3];
  logic [27:0] s;
  logic [31:0] mt[2] = '{32'h00FF_FFFE, 32'h0000_0000};
  logic [31:0] mr[2] = '{32'h0FFF_FFFE, 32'h0000_0000};

  // Free running 40 MHz clock.
  always #12.5 sys_clk = ~sys_clk;

  lvtpc_host_model lvtpc_host_model_i (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  lvtpc_top lvtpc_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .sample_strobe(strobe),
    .phase_a_voltage_sample(va), .phase_b_voltage_sample(vb), .phase_c_voltage_sample(vc),
    .phase_a_current_sample(ia), .phase_b_current_sample(ib), .phase_c_current_sample(ic),
    .neutral_current_sample(inn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .secondary_irq_n(irq_n),
    .neutral_rms_source_select(nsel), .comp_voltage_valid(cvalid),
    .comp_phase_a_voltage(ca), .comp_phase_b_voltage(cb), .comp_phase_c_voltage(cc));

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] e, input string what);
    n_checks++;
    if (got !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, e);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    lvtpc_host_model_i.acc(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    lvtpc_host_model_i.acc(1'b1, a, d);
  endtask

  // The interrupt level is registered twice behind its cause, so one more edge is let by.
  task automatic irq_is(input logic e);
    @(negedge sys_clk);
    chk({31'h0000_0000, irq_n}, {31'h0000_0000, e}, "irq level");
  endtask

  task automatic smp(input logic [23:0] a, b, c, i, j, k, n);
    @(negedge sys_clk);
    {va, vb, vc, ia, ib, ic, inn} = {a, b, c, i, j, k, n};
    strobe = 1'b1;
    @(negedge sys_clk);
    strobe = 1'b0;
    @(negedge sys_clk);
  endtask

  // Read data stands from the edge after the strobe; the oldest note is judged then.
  always @(posedge sys_clk) rd_taken <= reg_rd;
  always @(negedge sys_clk)
  begin
    if (rd_taken)
      chk(reg_rdata, exp_q.pop_front(), "read data");
  end

  // Watchdog sized well above the longest scenario, the phase shift wait.
  initial
  begin
    #1500000;
    n_errors++;
    close_out();
  end

  initial
  begin
    {va, vb, vc, ia, ib, ic, inn} = 168'h0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    rd(ADDR_SECONDARY_EVENT_FLAGS, 32'h0000_0000);
    rd(ADDR_MIS_THR, 32'h0000_0000);
    rd(8'h3F, 32'h0000_0000);
    irq_is(1'b1);
    // Junk above the calibration field must not survive.
    wr(ADDR_PHCAL_A, 32'hFFFF_FC00);
    wr(ADDR_PHCAL_A + 8'h01, 32'h0000_023F);
    wr(ADDR_PHCAL_A + 8'h02, 32'h0000_0064);
    rd(ADDR_PHCAL_A, 32'h0000_0000);
    rd(ADDR_PHCAL_A + 8'h01, 32'h0000_023F);
    wr(ADDR_OV_THR, 32'hAB5A_7540);
    wr(ADDR_OI_THR, 32'hAB5A_7540);
    wr(ADDR_MIS_THR, 32'h007F_FFFF);
    rd(ADDR_OV_THR, 32'h005A_7540);
    rd(ADDR_OI_THR, 32'h005A_7540);
    wr(ADDR_SECONDARY_EVENT_ENABLES, 32'h0016_0000);
    smp(24'h5A_7540, 24'hA5_8AC0, 24'h12_3456, 24'h5A_7540, 24'h0, 24'h0, 24'h5A_7540);
    at = '{0, 0, 0};
    for (int n = 2; n < 20000; n++)
    begin
      @(negedge sys_clk);
      for (int p = 0; p < 3; p++)
        if (cvalid[p] === 1'b1) at[p] = n;
    end
    // Step phase against the strobe allows up to two steps of slack.
    for (int p = 0; p < 3; p++)
      chk(32'((at[p] - (384 + sh[p]) * 40000 / 1024) inside {[-80:80]}), 1, "shift");
    chk({8'h00, ca}, 32'h005A_7540, "phase a data");
    chk({8'h00, cb}, 32'h00A5_8AC0, "phase b data");
    chk({8'h00, cc}, 32'h0012_3456, "phase c data");
    rd(ADDR_SECONDARY_EVENT_FLAGS, 32'h0000_0000);
    irq_is(1'b1);
    wr(ADDR_MIS_THR, 32'h0000_0064);
    smp(24'h0, 24'h0, 24'h0, 24'h00_03E8, 24'h00_07D0, 24'hFF_FE0C, 24'hFF_F6A0);
    rd(ADDR_PHASE_CURRENT_SUM, 32'h0000_09C4);
    rd(ADDR_PRIMARY_EVENT_FLAGS, 32'h0002_0000);
    wr(ADDR_PRIMARY_EVENT_FLAGS, 32'h0002_0000);
    rd(ADDR_PRIMARY_EVENT_FLAGS, 32'h0000_0000);
    rd(ADDR_SECONDARY_EVENT_FLAGS, 32'h0000_0000);
    smp(24'h0, 24'h0, 24'h0, 24'h00_03E8, 24'h00_07D0, 24'hFF_FE0C, 24'hFF_F6A1);
    rd(ADDR_SECONDARY_EVENT_FLAGS, 32'h0010_0000);
    irq_is(1'b0);
    wr(ADDR_SECONDARY_EVENT_FLAGS, 32'h0010_0000);
    irq_is(1'b1);
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_MIS_THR, mt[k]);
      rd(ADDR_MIS_THR, mr[k]);
      smp(24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0);
      rd(ADDR_SECONDARY_EVENT_FLAGS, 32'h0010_0000);
      wr(ADDR_SECONDARY_EVENT_FLAGS, 32'h0010_0000);
    end
    wr(ADDR_MIS_THR, 32'h007F_FFFF);
    wr(ADDR_OI_THR, 32'h0000_03E8);
    smp(24'h0, 24'h0, 24'h0, 24'h00_03E8, 24'hFF_FC17, 24'h0, 24'h0);
    rd(ADDR_SECONDARY_EVENT_FLAGS, 32'h0002_0000);
    rd(ADDR_PHASE_EVENT_SOURCE, 32'h0000_0010);
    irq_is(1'b0);
    smp(24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0);
    rd(ADDR_SECONDARY_EVENT_FLAGS, 32'h0002_0000);
    wr(ADDR_SECONDARY_EVENT_FLAGS, 32'h0002_0000);
    rd(ADDR_PHASE_EVENT_SOURCE, 32'h0000_0000);
    irq_is(1'b1);
    wr(ADDR_OV_THR, 32'h0000_01F4);
    smp(24'h00_01F4, 24'h0, 24'hFF_FE0B, 24'h0, 24'h0, 24'h0, 24'h0);
    rd(ADDR_PHASE_EVENT_SOURCE, 32'h0000_0800);
    rd(ADDR_SECONDARY_EVENT_FLAGS, 32'h0004_0000);
    irq_is(1'b0);
    wr(ADDR_SECONDARY_EVENT_ENABLES, 32'h0000_0000);
    irq_is(1'b1);
    wr(ADDR_OV_THR, 32'h0000_0000);
    wr(ADDR_SECONDARY_EVENT_FLAGS, 32'h0004_0000);
    smp(24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0);
    rd(ADDR_SECONDARY_EVENT_FLAGS, 32'h0004_0000);
    wr(ADDR_CONFIG, 32'h0000_0001);
    chk({31'h0000_0000, nsel}, 32'h0000_0001, "neutral select");
    rd(ADDR_CONFIG, 32'h0000_0001);
    // Both level thresholds at zero make every random sample trip all phases.
    wr(ADDR_OI_THR, 32'h0000_0000);
    // Random currents exercise the signed sum and its zero padded word.
    repeat (4)
    begin
      for (int p = 0; p < 3; p++)
        r[p] = 24'($random(seed));
      s = 28'($signed(r[0])) + 28'($signed(r[1])) + 28'($signed(r[2]));
      smp(24'h0, 24'h0, 24'h0, r[0], r[1], r[2], 24'h0);
      rd(ADDR_PHASE_CURRENT_SUM, {4'h0, s});
    end
    rd(ADDR_PHASE_EVENT_SOURCE, 32'h0000_0E38);
    @(negedge sys_clk);
    close_out();
  end
endmodule
`default_nettype wire
